// ===== logic/pdcs_ctl_status.v
`timescale 1ns/100ps
`include "pdcs_defines.vh"
// Overview of operation
// - bits 31:22 always read zero and ignore writes
// - bit 21 shows one while any non-posted request awaits completion
// - bit 20 reports detected auxiliary power; bridge works without it
// - bit 19 sets on unsupported request, clears on write of one
// - bit 18 sets on fatal error, clears on write of one
// - bit 17 sets on non-fatal error, clears on write of one
// - bit 16 sets on correctable error, clears on write of one
// - bit 15 enables retry status answers for configs below bridge
// - bits 14:12 cap read request size, reset to 512 bytes
// - bit 11 no-snoop enable is hardwired zero
// - bit 10 permits auxiliary power use beyond wake power
// - bit 9 phantom function enable is hardwired zero
// - bit 8 extended tag enable is hardwired zero
// - bits 7:5 payload setting, always transmitted as 128 bytes
// - bit 4 relaxed ordering enable is hardwired zero
// - bit 3 enables unsupported request reporting
// - bit 2 gates fatal error messages
// - bit 1 gates non-fatal error messages
// - bit 0 gates correctable error messages
// - payload capability advertised as 128 bytes bounds transmit, not the stored setting
module pdcs_ctl_status (
    // clock and reset
    input wire MCLK_I,
    input wire RSTN_I,
    // configuration access, dword address into config space
    input wire CFG_WR_I,
    input wire CFG_RD_I,
    input wire [9:0] CFG_ADDR_I,
    input wire [3:0] CFG_BE_I,
    input wire [31:0] CFG_WDATA_I,
    output reg [31:0] CFG_RDATA_O,
    output reg CFG_RVALID_O,
    // status sources
    input wire NP_PENDING_I,
    input wire AUX_DETECT_I,
    input wire UR_DETECT_I,
    input wire FATAL_DETECT_I,
    input wire NONFATAL_DETECT_I,
    input wire COR_DETECT_I,
    // controls to the bridge core
    output reg CRS_ENABLE_O,
    output reg AUX_USE_ENABLE_O,
    output reg [12:0] RDREQ_BYTES_O,
    output reg [12:0] PAYLOAD_BYTES_O,
    output reg UR_REPORT_O,
    output reg FATAL_REPORT_O,
    output reg NONFATAL_REPORT_O,
    output reg COR_REPORT_O
);

wire hit;
wire wr_hit;
wire [3:0] detect;
wire [3:0] flag;
wire [12:0] rdreq_bytes;
wire [12:0] payload_bytes;
wire [31:0] rd_word;
reg crs_en;
reg [2:0] rdreq;
reg auxuse_en;
reg [2:0] payload;
reg ur_en;
reg fatal_en;
reg nonfatal_en;
reg cor_en;
reg np_pending;
reg aux_det;

assign hit = (CFG_ADDR_I == `PDCS_DWORD_ADDR);
assign wr_hit = CFG_WR_I & hit;

// flag order: correctable, non-fatal, fatal, unsupported
assign detect = {UR_DETECT_I, FATAL_DETECT_I, NONFATAL_DETECT_I, COR_DETECT_I};

// the four sticky flags share byte 2; clear needs that byte enabled
genvar g;
generate
    for (g = 0; g < `PDCS_ERR_CNT; g = g + 1) begin : g_flag
        pdcs_w1c_flag u_flag (
            .clk_i(MCLK_I),
            .rst_n_i(RSTN_I),
            .set_i(detect[g]),
            .clr_i(wr_hit & CFG_BE_I[2] & CFG_WDATA_I[`PDCS_COR_SEEN + g]),
            .flag_o(flag[g])
        );
    end
endgenerate

// status inputs registered so the read word sees a stable copy
always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        np_pending <= 1'b0;
        aux_det <= 1'b0;
    end else begin
        np_pending <= NP_PENDING_I;
        aux_det <= AUX_DETECT_I;
    end
end

// writable controls, each byte lane guarded by its own enable
always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        crs_en <= 1'b0;
        rdreq <= `PDCS_RDREQ_RST;
        auxuse_en <= 1'b0;
        payload <= `PDCS_PAYLOAD_RST;
        ur_en <= 1'b0;
        fatal_en <= 1'b0;
        nonfatal_en <= 1'b0;
        cor_en <= 1'b0;
    end else if (wr_hit) begin
        if (CFG_BE_I[1]) begin
            crs_en <= CFG_WDATA_I[`PDCS_CRS_EN];
            rdreq <= CFG_WDATA_I[`PDCS_RDREQ_HI:`PDCS_RDREQ_LO];
            auxuse_en <= CFG_WDATA_I[`PDCS_AUXUSE_EN];
        end
        if (CFG_BE_I[0]) begin
            payload <= CFG_WDATA_I[`PDCS_PAYLOAD_HI:`PDCS_PAYLOAD_LO];
            ur_en <= CFG_WDATA_I[`PDCS_UR_EN];
            fatal_en <= CFG_WDATA_I[`PDCS_FATAL_EN];
            nonfatal_en <= CFG_WDATA_I[`PDCS_NONFATAL_EN];
            cor_en <= CFG_WDATA_I[`PDCS_COR_EN];
        end
    end
end

// byte limits for requester and transmitter
pdcs_size_decode u_size (
    .rdreq_i(rdreq),
    .payload_i(payload),
    .rdreq_bytes_o(rdreq_bytes),
    .payload_bytes_o(payload_bytes)
);

// assemble the word; hardwired bits are constant zeros
assign rd_word = {
    10'h000,
    np_pending,
    aux_det,
    flag[3], flag[2], flag[1], flag[0],
    crs_en,
    rdreq,
    1'b0,
    auxuse_en,
    1'b0,
    1'b0,
    payload,
    1'b0,
    ur_en,
    fatal_en,
    nonfatal_en,
    cor_en
};

// read answer one cycle after the request; other addresses read zero
always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        CFG_RDATA_O <= 32'h0000_0000;
        CFG_RVALID_O <= 1'b0;
    end else begin
        CFG_RVALID_O <= CFG_RD_I;
        if (CFG_RD_I && hit) begin
            CFG_RDATA_O <= rd_word;
        end else begin
            CFG_RDATA_O <= 32'h0000_0000;
        end
    end
end

// control outputs registered; transmit payload stays at capability size
always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        CRS_ENABLE_O <= 1'b0;
        AUX_USE_ENABLE_O <= 1'b0;
        RDREQ_BYTES_O <= `PDCS_RDREQ_RST_BYTES;
        PAYLOAD_BYTES_O <= `PDCS_BYTES_MIN;
        UR_REPORT_O <= 1'b0;
        FATAL_REPORT_O <= 1'b0;
        NONFATAL_REPORT_O <= 1'b0;
        COR_REPORT_O <= 1'b0;
    end else begin
        CRS_ENABLE_O <= crs_en;
        AUX_USE_ENABLE_O <= auxuse_en;
        RDREQ_BYTES_O <= rdreq_bytes;
        PAYLOAD_BYTES_O <= payload_bytes;
        UR_REPORT_O <= ur_en;
        FATAL_REPORT_O <= fatal_en;
        NONFATAL_REPORT_O <= nonfatal_en;
        COR_REPORT_O <= cor_en;
    end
end

endmodule // pdcs_ctl_status

// ===== include/pdcs_defines.vh
`ifndef PDCS_DEFINES_VH
`define PDCS_DEFINES_VH

// register location in configuration space (byte address)
`define PDCS_OFFSET 12'h0_0C8
`define PDCS_DWORD_ADDR 10'h0_32
`define PDCS_RESET 32'h0000_2000

// field positions
`define PDCS_PENDING 21
`define PDCS_AUX_DET 20
`define PDCS_UR_SEEN 19
`define PDCS_FATAL_SEEN 18
`define PDCS_NONFATAL_SEEN 17
`define PDCS_COR_SEEN 16
`define PDCS_CRS_EN 15
`define PDCS_RDREQ_HI 14
`define PDCS_RDREQ_LO 12
`define PDCS_AUXUSE_EN 10
`define PDCS_PAYLOAD_HI 7
`define PDCS_PAYLOAD_LO 5
`define PDCS_UR_EN 3
`define PDCS_FATAL_EN 2
`define PDCS_NONFATAL_EN 1
`define PDCS_COR_EN 0

// reset values of writable fields
`define PDCS_RDREQ_RST 3'h2
`define PDCS_PAYLOAD_RST 3'h0
// advertised payload capability: 000 means 128 bytes
`define PDCS_PAYLOAD_CAP 3'h0
// read request encodings above this are reserved
`define PDCS_RDREQ_MAX 3'h5
`define PDCS_ERR_CNT 4
// byte limits: smallest size, and the read limit for the reset encoding
`define PDCS_BYTES_MIN 13'h0080
`define PDCS_RDREQ_RST_BYTES 13'h0200

`endif

// ===== logic/pdcs_w1c_flag.v
`timescale 1ns/100ps
// one sticky error flag, write-one-to-clear, set wins over clear
module pdcs_w1c_flag (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // event and clear
    input wire set_i,
    input wire clr_i,
    // state
    output reg flag_o
);

// set has priority so a coinciding detection is never lost
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        flag_o <= 1'b0;
    end else if (set_i) begin
        flag_o <= 1'b1;
    end else if (clr_i) begin
        flag_o <= 1'b0;
    end
end

endmodule // pdcs_w1c_flag

// ===== logic/pdcs_size_decode.v
`timescale 1ns/100ps
`include "pdcs_defines.vh"
// turns size encodings into byte limits for the requester and transmitter logic
module pdcs_size_decode (
    // encodings
    input wire [2:0] rdreq_i,
    input wire [2:0] payload_i,
    // byte limits
    output reg [12:0] rdreq_bytes_o,
    output wire [12:0] payload_bytes_o
);

// every payload setting means 128 bytes on transmit
assign payload_bytes_o = `PDCS_BYTES_MIN;

// reserved encodings fall back to the smallest size, the safe choice
always @* begin
    if (rdreq_i > `PDCS_RDREQ_MAX) begin
        rdreq_bytes_o = `PDCS_BYTES_MIN;
    end else begin
        rdreq_bytes_o = `PDCS_BYTES_MIN << rdreq_i;
    end
end

endmodule // pdcs_size_decode

// ===== tb/pdcs_ctl_status_props.sv
`timescale 1ns/100ps
`include "pdcs_defines.vh"
module pdcs_chk (
    input logic MCLK_I, RSTN_I, CFG_WR_I, CFG_RD_I, CFG_RVALID_O,
    input logic [9:0] CFG_ADDR_I,
    input logic [3:0] CFG_BE_I,
    input logic [31:0] CFG_WDATA_I, CFG_RDATA_O,
    input logic NP_PENDING_I, AUX_DETECT_I, UR_DETECT_I, FATAL_DETECT_I, NONFATAL_DETECT_I, COR_DETECT_I,
    input logic CRS_ENABLE_O, AUX_USE_ENABLE_O, UR_REPORT_O, FATAL_REPORT_O, NONFATAL_REPORT_O, COR_REPORT_O,
    input logic [12:0] RDREQ_BYTES_O, PAYLOAD_BYTES_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    // short names keep the properties on one line
    wire hit = CFG_ADDR_I == `PDCS_DWORD_ADDR;
    wire wr1 = CFG_WR_I && hit && CFG_BE_I[1];
    wire [3:0] det = {UR_DETECT_I, FATAL_DETECT_I, NONFATAL_DETECT_I, COR_DETECT_I};
    wire [2:0] rq = CFG_WDATA_I[14:12];
    wire [1:0] cw = {CFG_WDATA_I[15], CFG_WDATA_I[10]};
    wire [3:0] rw = CFG_WDATA_I[3:0];
    wire [1:0] st = {NP_PENDING_I, AUX_DETECT_I};
    upper_zero_a: assert property (CFG_RVALID_O |-> CFG_RDATA_O[31:22] == 10'h000)
        else $error("upper bits read nonzero");
    fixed_zero_a: assert property (CFG_RVALID_O |-> {CFG_RDATA_O[11], CFG_RDATA_O[9:8], CFG_RDATA_O[4]} == 4'h0)
        else $error("hardwired bit read one");
    status_copy_a: assert property (CFG_RD_I && hit && $past(RSTN_I) |=> CFG_RDATA_O[21:20] == $past(st, 2))
        else $error("status bits wrong");
    flag_set_a: assert property (CFG_RD_I && hit && $past(RSTN_I) |=> (CFG_RDATA_O[19:16] & $past(det, 2)) == $past(det, 2))
        else $error("detected error not flagged");
    miss_zero_a: assert property (CFG_RD_I && !hit |=> CFG_RDATA_O == 32'h0000_0000)
        else $error("unmapped read nonzero");
    payload_fixed_a: assert property (PAYLOAD_BYTES_O == 13'h0080)
        else $error("payload limit not 128");
    rdreq_limit_a: assert property (wr1 |-> ##2 RDREQ_BYTES_O == ($past(rq, 2) > 3'h5 ? 13'h0080 : 13'h0080 << $past(rq, 2)))
        else $error("read request limit wrong");
    ctl_follow_a: assert property (wr1 |-> ##2 {CRS_ENABLE_O, AUX_USE_ENABLE_O} == $past(cw, 2))
        else $error("retry or aux enable wrong");
    report_follow_a: assert property (CFG_WR_I && hit && CFG_BE_I[0] |-> ##2
        {UR_REPORT_O, FATAL_REPORT_O, NONFATAL_REPORT_O, COR_REPORT_O} == $past(rw, 2))
        else $error("report enables wrong");
endmodule // pdcs_chk
bind pdcs_ctl_status pdcs_chk u_chk (.*);

// ===== tb/pdcs_cfg_host.sv
`timescale 1ns/100ps
// config software stand-in; one idle cycle after a write, two after a read
module pdcs_cfg_host (
    input logic clk_i,
    input logic rvalid_i,
    input logic [31:0] rdata_i,
    output logic wr_o, rd_o,
    output logic [9:0] addr_o,
    output logic [3:0] be_o,
    output logic [31:0] wdata_o
);
    initial begin
        {wr_o, rd_o, addr_o, be_o, wdata_o} = '0;
    end
    // write: strobe for one edge, then data inverted so stale values are never trusted
    task wr(input logic [9:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_i);
        {wr_o, addr_o, be_o, wdata_o} <= {1'b1, a, b, d};
        @(posedge clk_i);
        {wr_o, wdata_o} <= {1'b0, ~d};
    endtask
    // read: data taken at the edge where rvalid is seen
    task rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk_i);
        {rd_o, addr_o} <= {1'b1, a};
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        d = (rvalid_i === 1'b1) ? rdata_i : 32'hxxxx_xxxx;
    endtask
endmodule // pdcs_cfg_host

// ===== tb/pdcs_ctl_status_tb_top.sv
`timescale 1ns/100ps
`include "pdcs_defines.vh"
module pdcs_ctl_status_tb_top;
    localparam logic [9:0] A = `PDCS_DWORD_ADDR;
    logic clk = 1'b0, rst_n = 1'b0, wr, rd, rv, np = 1'b0, aux = 1'b0;
    logic [3:0] det = 4'h0, be;
    logic [9:0] addr;
    logic [31:0] wd, rdat, got;
    logic [12:0] rq_b, pl_b;
    logic [5:0] ctl;
    int err_total = 0, n_tests = 0, cyc = 0;
    initial forever #12.5 clk = ~clk;
    pdcs_cfg_host host (.clk_i(clk), .rvalid_i(rv), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .addr_o(addr),
        .be_o(be), .wdata_o(wd));
    pdcs_ctl_status dut (.MCLK_I(clk), .RSTN_I(rst_n), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr),
        .CFG_BE_I(be), .CFG_WDATA_I(wd), .CFG_RDATA_O(rdat), .CFG_RVALID_O(rv), .NP_PENDING_I(np),
        .AUX_DETECT_I(aux), .UR_DETECT_I(det[3]), .FATAL_DETECT_I(det[2]), .NONFATAL_DETECT_I(det[1]),
        .COR_DETECT_I(det[0]), .CRS_ENABLE_O(ctl[5]), .AUX_USE_ENABLE_O(ctl[4]), .RDREQ_BYTES_O(rq_b),
        .PAYLOAD_BYTES_O(pl_b), .UR_REPORT_O(ctl[3]), .FATAL_REPORT_O(ctl[2]), .NONFATAL_REPORT_O(ctl[1]),
        .COR_REPORT_O(ctl[0]));
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rdchk(input logic [9:0] a, input logic [31:0] e);
        host.rd(a, got);
        chk(got, e);
    endtask
    task give_verdict;
        $display("errors=%0d checks=%0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // reset values of word and limits
    task t_reset;
        rdchk(A, 32'h0000_2000);
        chk({19'h0, rq_b}, 32'd512);
        chk({19'h0, pl_b}, 32'd128);
    endtask
    // all ones except payload, which software keeps at the advertised 000
    task t_ctl;
        host.wr(A, 4'hF, 32'hFFFF_FF1F);
        rdchk(A, 32'h0000_F40F);
        chk({26'h0, ctl}, 32'h3F);
        chk({19'h0, rq_b}, 32'h80);
        for (int i = 0; i < 6; i++) begin
            host.wr(A, 4'h2, {17'h0, i[2:0], 12'h000});
            host.rd(A, got);
            chk({19'h0, rq_b}, 32'h80 << i);
        end
        host.wr(A, 4'h1, 32'hFFFF_FF00);
        rdchk(A, 32'h0000_5000);
        chk({26'h0, ctl}, 32'h0);
    endtask
    // sticky flags, zero writes, clear racing a new detection
    task t_err;
        @(posedge clk) det <= 4'hF;
        @(posedge clk) det <= 4'h0;
        rdchk(A, 32'h000F_5000);
        host.wr(A, 4'h4, 32'h0000_0000);
        rdchk(A, 32'h000F_5000);
        host.wr(A, 4'hB, 32'h000F_5000);
        rdchk(A, 32'h000F_5000);
        fork
            host.wr(A, 4'h4, 32'h0005_0000);
            begin
                @(posedge clk) det <= 4'h4;
                @(posedge clk) det <= 4'h0;
            end
        join
        rdchk(A, 32'h000E_5000);
    endtask
    task t_stat;
        @(posedge clk) {np, aux} <= 2'b11;
        rdchk(A, 32'h003E_5000);
        @(posedge clk) {np, aux} <= 2'b00;
        rdchk(A, 32'h000E_5000);
    endtask
    task t_miss;
        host.wr(10'h033, 4'hF, 32'hFFFF_FFFF);
        rdchk(10'h033, 32'h0000_0000);
        rdchk(A, 32'h000E_5000);
    endtask
    // hang guard, far above the roughly 80 cycles used
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_ctl;
        t_err;
        t_stat;
        t_miss;
        give_verdict;
    end
endmodule // pdcs_ctl_status_tb_top
